// *** include/dbr_pkg.sv ***
// Constants and types for the debug authentication and status registers
package dbr_pkg;
  // Coprocessor register encodings
  localparam logic [3:0] COPROC_DBG = 4'he;
  localparam logic [2:0] AUTH_OPC1 = 3'h0;
  localparam logic [3:0] AUTH_CRN = 4'h7;
  localparam logic [3:0] AUTH_CRM = 4'he;
  localparam logic [2:0] AUTH_OPC2 = 3'h6;
  localparam logic [2:0] DSCR_OPC1 = 3'h0;
  localparam logic [3:0] DSCR_CRN = 4'h0;
  localparam logic [3:0] DSCR_CRM = 4'h2;
  localparam logic [2:0] DSCR_OPC2 = 3'h2;
  // Privilege levels
  localparam logic [1:0] LVL_USER = 2'h0;
  localparam logic [1:0] LVL_KERNEL = 2'h1;
  localparam logic [1:0] LVL_HYP = 2'h2;
  // Status and control word bit positions
  localparam int RXF_BIT = 30;
  localparam int TXF_BIT = 29;
  localparam int RXO_BIT = 27;
  localparam int TXU_BIT = 26;
  localparam int INTD_LSB = 22;
  localparam int TDA_BIT = 21;
  localparam int WORLD_BIT = 18;
  localparam int MON_BIT = 15;
  localparam int HALT_BIT = 14;
  localparam int UCT_BIT = 12;
  localparam int ERR_BIT = 6;
  // Defined reset values and authentication field encodings
  localparam logic MON_RST = 1'h0;
  localparam logic UCT_RST = 1'h0;
  localparam logic [1:0] FIELD_ON = 2'h3;
  localparam logic [1:0] FIELD_OFF = 2'h2;
  localparam logic [1:0] FIELD_NONE = 2'h0;

  // Image of the external debug status bits
  typedef struct packed {
    logic rx_full;
    logic tx_full;
    logic rx_overrun;
    logic tx_underrun;
    logic [1:0] int_dis;
    logic trap_da;
    logic halt_en;
    logic err;
  } dbr_eds_t;

  // Registered answer to a coprocessor access
  typedef struct packed {
    logic valid;
    logic trap_hyp;
    logic trap_undef;
    logic [31:0] rdata;
  } dbr_rsp_t;
endpackage

// *** rtl/dbr_regs.sv ***
// Debug authentication status and external-view debug status/control registers
//
// Overview of operation
// - Bits 11:10 report hyp non-invasive state
// - Hyp present: bit 11 one; else 11:10 zero
// - Bits 9:8 report hyp invasive state
// - Hyp present: bit 9 one; else 9:8 zero
// - Secure debug fields always read zero
// - Bits 3:2 show non-invasive enable, 10/11
// - Bits 1:0 show invasive enable, 10/11
// - Authentication word read-only, kernel and hyp only
// - Hyp trap bit traps kernel reads
// - Lock clear: image fields read-only
// - Lock set: images writable, mirror external status
// - Receive-full bit 30, transmit-full bit 29
// - Overrun bit 27, underrun bit 26
// - Interrupt-disable 23:22, trap-access bit 21
// - Halting-enable bit 14, error bit 6
// - Bit 18 one, bits 17 and 16 zero
// - Monitor enable bit 15 gates debug exceptions
// - User comms trap bit 12, resets zero
// - Trap covers every access form
// - Debug state ignores trap on transfer registers
// - Warm reset clears defined fields only
`timescale 1ns/100ps
`default_nettype none
module dbr_regs
  import dbr_pkg::*;
#(
  parameter bit HYP_LEVEL = 1'b1
)
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_DCC,
  input wire logic REQ_DTR,
  input wire logic [3:0] REQ_COPROC,
  input wire logic [2:0] REQ_OPC1,
  input wire logic [3:0] REQ_CRN,
  input wire logic [3:0] REQ_CRM,
  input wire logic [2:0] REQ_OPC2,
  input wire logic [1:0] REQ_LEVEL,
  input wire logic [31:0] REQ_WDATA,
  input wire logic HYP_TDA,
  input wire logic DEBUG_STATE,
  input wire logic OS_LOCK,
  input wire dbr_eds_t EDS_IN,
  input wire logic HYP_NI_EN,
  input wire logic HYP_I_EN,
  input wire logic NS_NI_EN,
  input wire logic NS_I_EN,
  output var dbr_rsp_t RSP,
  output var logic EDS_WR_VALID,
  output var dbr_eds_t EDS_WR_DATA,
  output var logic MON_DEBUG_EN,
  output var logic USER_COMMS_TRAP
);

  // ------------------------------------------------------------
  // Authentication pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end
    else if (CE)
    begin
      pin_meta_reg <= {HYP_NI_EN, HYP_I_EN, NS_NI_EN, NS_I_EN};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // Authentication status word
  // ------------------------------------------------------------
  logic [1:0] hyp_noninvasive_state;
  logic [1:0] hyp_invasive_state;
  logic [1:0] nonsecure_noninvasive_state;
  logic [1:0] nonsecure_invasive_state;
  logic [31:0] auth_word;

  always_comb
  begin
    hyp_noninvasive_state = FIELD_NONE;
    hyp_invasive_state = FIELD_NONE;
    if (HYP_LEVEL)
    begin
      hyp_noninvasive_state = pin_sync_reg[3] ? FIELD_ON : FIELD_OFF;
      hyp_invasive_state = pin_sync_reg[2] ? FIELD_ON : FIELD_OFF;
    end
    nonsecure_noninvasive_state = pin_sync_reg[1] ? FIELD_ON : FIELD_OFF;
    nonsecure_invasive_state = pin_sync_reg[0] ? FIELD_ON : FIELD_OFF;
    auth_word = 32'h0;
    auth_word[11:10] = hyp_noninvasive_state;
    auth_word[9:8] = hyp_invasive_state;
    auth_word[7:6] = FIELD_NONE;
    auth_word[5:4] = FIELD_NONE;
    auth_word[3:2] = nonsecure_noninvasive_state;
    auth_word[1:0] = nonsecure_invasive_state;
  end

  // ------------------------------------------------------------
  // Status and control word view
  // ------------------------------------------------------------
  logic mon_reg;
  logic mon_next;
  logic uct_reg;
  logic uct_next;
  logic [31:0] dscr_word;
  dbr_eds_t wr_img;

  always_comb
  begin
    dscr_word = 32'h0;
    dscr_word[RXF_BIT] = EDS_IN.rx_full;
    dscr_word[TXF_BIT] = EDS_IN.tx_full;
    dscr_word[RXO_BIT] = EDS_IN.rx_overrun;
    dscr_word[TXU_BIT] = EDS_IN.tx_underrun;
    dscr_word[INTD_LSB +: 2] = EDS_IN.int_dis;
    dscr_word[TDA_BIT] = EDS_IN.trap_da;
    dscr_word[WORLD_BIT] = 1'b1;
    dscr_word[MON_BIT] = mon_reg;
    dscr_word[HALT_BIT] = EDS_IN.halt_en;
    dscr_word[UCT_BIT] = uct_reg;
    dscr_word[ERR_BIT] = EDS_IN.err;
    wr_img.rx_full = REQ_WDATA[RXF_BIT];
    wr_img.tx_full = REQ_WDATA[TXF_BIT];
    wr_img.rx_overrun = REQ_WDATA[RXO_BIT];
    wr_img.tx_underrun = REQ_WDATA[TXU_BIT];
    wr_img.int_dis = REQ_WDATA[INTD_LSB +: 2];
    wr_img.trap_da = REQ_WDATA[TDA_BIT];
    wr_img.halt_en = REQ_WDATA[HALT_BIT];
    wr_img.err = REQ_WDATA[ERR_BIT];
  end

  // ------------------------------------------------------------
  // Access decode and answer
  // ------------------------------------------------------------
  logic hit_auth;
  logic hit_dscr;
  logic hyp_trap_on;
  dbr_rsp_t rsp_reg;
  dbr_rsp_t rsp_next;
  logic eds_wr_reg;
  logic eds_wr_next;
  dbr_eds_t eds_data_reg;
  dbr_eds_t eds_data_next;

  always_comb
  begin
    hit_auth = 1'b0;
    hit_dscr = 1'b0;
    if (REQ_COPROC == COPROC_DBG && REQ_OPC1 == AUTH_OPC1 && REQ_CRN == AUTH_CRN
        && REQ_CRM == AUTH_CRM && REQ_OPC2 == AUTH_OPC2)
    begin
      hit_auth = 1'b1;
    end
    else if (REQ_COPROC == COPROC_DBG && REQ_OPC1 == DSCR_OPC1 && REQ_CRN == DSCR_CRN
             && REQ_CRM == DSCR_CRM && REQ_OPC2 == DSCR_OPC2)
    begin
      hit_dscr = 1'b1;
    end
    hyp_trap_on = HYP_LEVEL && HYP_TDA && REQ_LEVEL == LVL_KERNEL;
    rsp_next = '0;
    mon_next = mon_reg;
    uct_next = uct_reg;
    eds_wr_next = 1'b0;
    eds_data_next = eds_data_reg;
    if (REQ_VALID)
    begin
      rsp_next.valid = 1'b1;
      if (REQ_DCC)
      begin
        // Any form of comms-channel access, including load/store and pair reads
        rsp_next.trap_undef = REQ_LEVEL == LVL_USER && uct_reg
                              && !(DEBUG_STATE && REQ_DTR);
      end
      else if (hit_auth)
      begin
        if (REQ_WRITE || REQ_LEVEL == LVL_USER)
        begin
          rsp_next.trap_undef = 1'b1;
        end
        else if (hyp_trap_on)
        begin
          rsp_next.trap_hyp = 1'b1;
        end
        else
        begin
          rsp_next.rdata = auth_word;
        end
      end
      else if (hit_dscr)
      begin
        if (REQ_LEVEL == LVL_USER)
        begin
          rsp_next.trap_undef = 1'b1;
        end
        else if (hyp_trap_on)
        begin
          rsp_next.trap_hyp = 1'b1;
        end
        else if (REQ_WRITE)
        begin
          mon_next = REQ_WDATA[MON_BIT];
          uct_next = REQ_WDATA[UCT_BIT];
          if (OS_LOCK)
          begin
            eds_wr_next = 1'b1;
            eds_data_next = wr_img;
          end
          // Lock clear: image bits of the write are dropped
        end
        else
        begin
          rsp_next.rdata = dscr_word;
        end
      end
      else
      begin
        rsp_next.trap_undef = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rsp_reg <= '0;
      mon_reg <= MON_RST;
      uct_reg <= UCT_RST;
      eds_wr_reg <= 1'b0;
      eds_data_reg <= '0;
    end
    else if (CE)
    begin
      rsp_reg <= rsp_next;
      mon_reg <= mon_next;
      uct_reg <= uct_next;
      eds_wr_reg <= eds_wr_next;
      eds_data_reg <= eds_data_next;
    end
  end

  assign RSP = rsp_reg;
  assign EDS_WR_VALID = eds_wr_reg;
  assign EDS_WR_DATA = eds_data_reg;
  assign MON_DEBUG_EN = mon_reg;
  assign USER_COMMS_TRAP = uct_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  logic auth_rd;
  logic dscr_rd;
  logic dscr_wr;
  assign auth_rd = CE && REQ_VALID && !REQ_DCC && hit_auth && !REQ_WRITE && REQ_LEVEL == LVL_HYP;
  assign dscr_rd = CE && REQ_VALID && !REQ_DCC && hit_dscr && !REQ_WRITE && REQ_LEVEL == LVL_HYP;
  assign dscr_wr = CE && REQ_VALID && !REQ_DCC && hit_dscr && REQ_WRITE && REQ_LEVEL == LVL_HYP;

  hyp_ni_field_a: assert property (auth_rd |=>
    RSP.rdata[11:10] == (HYP_LEVEL ? {1'b1, $past(pin_sync_reg[3])} : 2'h0))
    else $error("hyp non-invasive field wrong");
  hyp_i_field_a: assert property (auth_rd |=>
    RSP.rdata[9:8] == (HYP_LEVEL ? {1'b1, $past(pin_sync_reg[2])} : 2'h0))
    else $error("hyp invasive field wrong");
  auth_low_fields_a: assert property (auth_rd |=>
    RSP.rdata[31:12] == 20'h0 && RSP.rdata[7:4] == 4'h0 && RSP.rdata[3] && RSP.rdata[1])
    else $error("auth fixed fields wrong");
  pin_to_ns_a: assert property ((CE && $stable(NS_I_EN)) [*2] ##1 auth_rd |=>
    RSP.rdata[0] == $past(NS_I_EN, 2))
    else $error("invasive enable not reported");
  auth_user_undef_a: assert property (CE && REQ_VALID && !REQ_DCC && hit_auth && REQ_LEVEL == LVL_USER |=>
    RSP.valid && RSP.trap_undef && RSP.rdata == 32'h0)
    else $error("user read of auth word not refused");
  auth_write_undef_a: assert property (CE && REQ_VALID && !REQ_DCC && hit_auth && REQ_WRITE |=>
    RSP.valid && RSP.trap_undef && !RSP.trap_hyp && RSP.rdata == 32'h0)
    else $error("write of auth word not refused");
  kernel_hyp_trap_a: assert property (CE && REQ_VALID && !REQ_DCC && hit_auth && !REQ_WRITE
    && REQ_LEVEL == LVL_KERNEL && HYP_TDA |=> RSP.trap_hyp == HYP_LEVEL)
    else $error("kernel read trap wrong");
  locked_write_a: assert property (dscr_wr |=> EDS_WR_VALID == $past(OS_LOCK)
    && (!EDS_WR_VALID || EDS_WR_DATA.err == $past(REQ_WDATA[ERR_BIT])))
    else $error("image write gating wrong");
  dscr_layout_a: assert property (dscr_rd |=> RSP.rdata[18] && RSP.rdata[17:16] == 2'h0
    && RSP.rdata[30] == $past(EDS_IN.rx_full) && RSP.rdata[15] == $past(mon_reg))
    else $error("status word layout wrong");
  dscr_images_a: assert property (dscr_rd |=> RSP.rdata[29] == $past(EDS_IN.tx_full)
    && RSP.rdata[27:26] == $past({EDS_IN.rx_overrun, EDS_IN.tx_underrun})
    && RSP.rdata[23:21] == $past({EDS_IN.int_dis, EDS_IN.trap_da}))
    else $error("status word image bits wrong");
  dscr_halt_err_a: assert property (dscr_rd |=> RSP.rdata[14] == $past(EDS_IN.halt_en)
    && RSP.rdata[6] == $past(EDS_IN.err))
    else $error("halt or error image wrong");
  dscr_reserved_a: assert property (dscr_rd |=> RSP.rdata[31] == 1'b0 && RSP.rdata[28] == 1'b0
    && RSP.rdata[25:24] == 2'h0 && RSP.rdata[20:19] == 2'h0 && RSP.rdata[13] == 1'b0
    && RSP.rdata[11:7] == 5'h0 && RSP.rdata[5:0] == 6'h0)
    else $error("status word reserved bits set");
  comms_trap_a: assert property (CE && REQ_VALID && REQ_DCC && REQ_LEVEL == LVL_USER |=>
    RSP.trap_undef == $past(uct_reg && !(DEBUG_STATE && REQ_DTR)))
    else $error("comms trap wrong");
  mon_write_a: assert property (dscr_wr |=> MON_DEBUG_EN == $past(REQ_WDATA[MON_BIT])
    && USER_COMMS_TRAP == $past(REQ_WDATA[UCT_BIT]))
    else $error("control bits not written");
endmodule
`default_nettype wire

// *** verification/dbr_ext_model.sv ***
// External debug status register seen behind the save/restore images
`timescale 1ns/100ps
`default_nettype none
module dbr_ext_model
  import dbr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_valid,
  input wire dbr_eds_t wr_data,
  output var dbr_eds_t eds
);
  dbr_eds_t eds_reg;
  dbr_eds_t eds_next;

  always_comb
  begin
    eds_next = wr_valid ? wr_data : eds_reg;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      eds_reg <= 9'h0;
    else
      eds_reg <= eds_next;
  end

  assign eds = eds_reg;
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking testbench for the debug register block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dbr_pkg::*;
  logic MCLK = 1'h0;
  logic RST_B = 1'h0;
  logic CE = 1'h1;
  logic REQ_VALID = 1'h0, REQ_WRITE = 1'h0, REQ_DCC = 1'h0, REQ_DTR = 1'h0;
  logic HYP_TDA = 1'h0, DEBUG_STATE = 1'h0, OS_LOCK = 1'h0;
  logic HYP_NI_EN = 1'h0, HYP_I_EN = 1'h0, NS_NI_EN = 1'h0, NS_I_EN = 1'h0;
  logic [3:0] REQ_COPROC = 4'h0, REQ_CRN = 4'h0, REQ_CRM = 4'h0;
  logic [2:0] REQ_OPC1 = 3'h0, REQ_OPC2 = 3'h0;
  logic [1:0] REQ_LEVEL = 2'h0;
  logic [31:0] REQ_WDATA = 32'h0;
  dbr_eds_t EDS_IN, EDS_WR_DATA, exp_eds;
  dbr_rsp_t RSP, rsp;
  logic EDS_WR_VALID, MON_DEBUG_EN, USER_COMMS_TRAP, wrv;
  int fails = 0;
  int total_checks = 0;

  dbr_regs #(.HYP_LEVEL(1'h1)) i_dut (.MCLK(MCLK), .RST_B(RST_B), .CE(CE), .REQ_VALID(REQ_VALID),
    .REQ_WRITE(REQ_WRITE), .REQ_DCC(REQ_DCC), .REQ_DTR(REQ_DTR), .REQ_COPROC(REQ_COPROC),
    .REQ_OPC1(REQ_OPC1), .REQ_CRN(REQ_CRN), .REQ_CRM(REQ_CRM), .REQ_OPC2(REQ_OPC2), .REQ_LEVEL(REQ_LEVEL),
    .REQ_WDATA(REQ_WDATA), .HYP_TDA(HYP_TDA), .DEBUG_STATE(DEBUG_STATE), .OS_LOCK(OS_LOCK), .EDS_IN(EDS_IN),
    .HYP_NI_EN(HYP_NI_EN), .HYP_I_EN(HYP_I_EN), .NS_NI_EN(NS_NI_EN), .NS_I_EN(NS_I_EN), .RSP(RSP),
    .EDS_WR_VALID(EDS_WR_VALID), .EDS_WR_DATA(EDS_WR_DATA), .MON_DEBUG_EN(MON_DEBUG_EN),
    .USER_COMMS_TRAP(USER_COMMS_TRAP));
  dbr_ext_model i_ext (.clk(MCLK), .rst_b(RST_B), .wr_valid(EDS_WR_VALID), .wr_data(EDS_WR_DATA), .eds(EDS_IN));

  task test_done;
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic dbr_eds_t img(input logic [31:0] w);
    return {w[30], w[29], w[27], w[26], w[23:22], w[21], w[14], w[6]};
  endfunction

  function automatic logic [31:0] dscr(input dbr_eds_t e, input logic m, input logic u);
    return {1'h0, e.rx_full, e.tx_full, 1'h0, e.rx_overrun, e.tx_underrun, 2'h0, e.int_dis, e.trap_da, 2'h0,
      1'h1, 2'h0, m, e.halt_en, 1'h0, u, 5'h0, e.err, 6'h0};
  endfunction

  // One access: drive after a falling edge, sample the registered answer one cycle on
  task acc(input logic w, input logic [1:0] lv, input logic [1:0] sel, input logic [31:0] wd,
    input logic dcc, input logic [1:0] et);
    @(negedge MCLK);
    REQ_VALID = 1'h1;
    REQ_WRITE = w;
    REQ_LEVEL = lv;
    REQ_WDATA = wd;
    REQ_DCC = dcc;
    REQ_COPROC = COPROC_DBG;
    if (sel == 2'h0)
      {REQ_OPC1, REQ_CRN, REQ_CRM, REQ_OPC2} = {AUTH_OPC1, AUTH_CRN, AUTH_CRM, AUTH_OPC2};
    else if (sel == 2'h1)
      {REQ_OPC1, REQ_CRN, REQ_CRM, REQ_OPC2} = {DSCR_OPC1, DSCR_CRN, DSCR_CRM, DSCR_OPC2};
    else
      {REQ_OPC1, REQ_CRN, REQ_CRM, REQ_OPC2} = 14'h3fff;
    @(negedge MCLK);
    rsp = RSP;
    wrv = EDS_WR_VALID;
    REQ_VALID = 1'h0;
    REQ_DCC = 1'h0;
    chk({31'h0, rsp.valid}, 32'h1);
    chk({30'h0, rsp.trap_hyp, rsp.trap_undef}, {30'h0, et});
    if (et != 2'h0)
      chk(rsp.rdata, 32'h0);
  endtask

  task t_auth;
    for (int i = 0; i < 16; i++)
    begin
      {HYP_NI_EN, HYP_I_EN, NS_NI_EN, NS_I_EN} = i[3:0];
      repeat (2) @(negedge MCLK);
      acc(1'h0, LVL_HYP, 2'h0, 32'h0, 1'h0, 2'h0);
      chk({28'h0, rsp.rdata[11:8]}, {28'h0, 1'h1, i[3], 1'h1, i[2]});
      chk({4'h0, rsp.rdata[31:12], rsp.rdata[7:0]}, {28'h0, 1'h1, i[1], 1'h1, i[0]});
    end
  endtask

  task t_traps;
    acc(1'h0, LVL_USER, 2'h0, 32'h0, 1'h0, 2'h1);
    acc(1'h1, LVL_KERNEL, 2'h0, 32'hffff_ffff, 1'h0, 2'h1);
    acc(1'h0, LVL_USER, 2'h1, 32'h0, 1'h0, 2'h1);
    acc(1'h0, LVL_KERNEL, 2'h2, 32'h0, 1'h0, 2'h1);
    HYP_TDA = 1'h1;
    acc(1'h0, LVL_KERNEL, 2'h0, 32'h0, 1'h0, 2'h2);
    acc(1'h0, LVL_KERNEL, 2'h1, 32'h0, 1'h0, 2'h2);
    acc(1'h0, LVL_HYP, 2'h0, 32'h0, 1'h0, 2'h0);
    HYP_TDA = 1'h0;
  endtask

  task t_status;
    OS_LOCK = 1'h0;
    acc(1'h1, LVL_KERNEL, 2'h1, 32'hffff_ffff, 1'h0, 2'h0);
    chk({31'h0, wrv}, 32'h0);
    chk({30'h0, MON_DEBUG_EN, USER_COMMS_TRAP}, 32'h3);
    acc(1'h0, LVL_KERNEL, 2'h1, 32'h0, 1'h0, 2'h0);
    chk(rsp.rdata, dscr(exp_eds, 1'h1, 1'h1));
    OS_LOCK = 1'h1;
    for (int k = 0; k < 2; k++)
    begin
      acc(1'h1, LVL_HYP, 2'h1, k ? 32'hffff_ffff : 32'h4420_4040, 1'h0, 2'h0);
      exp_eds = img(k ? 32'hffff_ffff : 32'h4420_4040);
      chk({31'h0, wrv}, 32'h1);
      chk({23'h0, EDS_WR_DATA}, {23'h0, exp_eds});
      chk({30'h0, MON_DEBUG_EN, USER_COMMS_TRAP}, {30'h0, k[0], k[0]});
      acc(1'h0, LVL_HYP, 2'h1, 32'h0, 1'h0, 2'h0);
      chk(rsp.rdata, dscr(exp_eds, k[0], k[0]));
    end
  endtask

  task t_dcc;
    for (int i = 0; i < 8; i++)
    begin
      DEBUG_STATE = i[1];
      REQ_DTR = i[0];
      acc(i[2], LVL_USER, 2'h2, 32'h0, 1'h1, {1'h0, i[1:0] != 2'h3});
    end
    DEBUG_STATE = 1'h0;
    acc(1'h0, LVL_KERNEL, 2'h2, 32'h0, 1'h1, 2'h0);
    acc(1'h1, LVL_KERNEL, 2'h1, 32'h0, 1'h0, 2'h0);
    exp_eds = 9'h0;
    acc(1'h0, LVL_USER, 2'h2, 32'h0, 1'h1, 2'h0);
  endtask

  // Clock enable low: a write must leave the control bits untouched
  task t_ce;
    CE = 1'h0;
    acc(1'h1, LVL_KERNEL, 2'h1, 32'h0000_9000, 1'h0, 2'h0);
    CE = 1'h1;
    chk({30'h0, MON_DEBUG_EN, USER_COMMS_TRAP}, 32'h0);
  endtask

  task t_rst;
    acc(1'h1, LVL_KERNEL, 2'h1, 32'h0000_9000, 1'h0, 2'h0);
    chk({30'h0, MON_DEBUG_EN, USER_COMMS_TRAP}, 32'h3);
    RST_B = 1'h0;
    @(negedge MCLK);
    chk({30'h0, MON_DEBUG_EN, USER_COMMS_TRAP}, 32'h0);
    RST_B = 1'h1;
    exp_eds = 9'h0;
    acc(1'h0, LVL_HYP, 2'h1, 32'h0, 1'h0, 2'h0);
    chk(rsp.rdata, dscr(exp_eds, 1'h0, 1'h0));
  endtask

  initial
  begin
    forever #50 MCLK = ~MCLK;
  end

  initial
  begin
    #200000;
    fails++;
    test_done;
  end

  initial
  begin
    exp_eds = 9'h0;
    repeat (16) @(posedge MCLK);
    @(negedge MCLK);
    RST_B = 1'h1;
    chk({30'h0, MON_DEBUG_EN, USER_COMMS_TRAP}, 32'h0);
    chk({31'h0, RSP.valid}, 32'h0);
    t_auth;
    t_traps;
    t_status;
    t_dcc;
    t_rst;
    t_ce;
    test_done;
  end
endmodule
`default_nettype wire
